// File: dbg_cmd_pkg.sv
package dbg_cmd_pkg;
    // command bytes
    localparam logic [7:0] CMD_REV_RD = 8'h00;
    localparam logic [7:0] CMD_STAT_RD = 8'h02;
    localparam logic [7:0] CMD_CNT_RD = 8'h03;
    localparam logic [7:0] CMD_CTL_WR = 8'h04;
    localparam logic [7:0] CMD_CTL_RD = 8'h05;
    localparam logic [7:0] CMD_PC_WR = 8'h06;
    localparam logic [7:0] CMD_PC_RD = 8'h07;
    localparam logic [7:0] CMD_REG_WR = 8'h08;
    localparam logic [7:0] CMD_REG_RD = 8'h09;
    localparam logic [7:0] CMD_PMEM_WR = 8'h0A;
    localparam logic [7:0] CMD_PMEM_RD = 8'h0B;
    localparam logic [7:0] CMD_DMEM_WR = 8'h0C;
    localparam logic [7:0] CMD_DMEM_RD = 8'h0D;
    localparam logic [7:0] CMD_CRC_RD = 8'h0E;
    localparam logic [7:0] CMD_STEP = 8'h10;
    localparam logic [7:0] CMD_STUFF = 8'h11;
    localparam logic [7:0] CMD_EXEC = 8'h12;
    // control register fields and reset value
    localparam int CTL_DEBUG_STATE_BIT = 7;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // status register field positions
    localparam int STAT_DEBUG_BIT = 7;
    localparam int STAT_HALT_BIT = 6;
    localparam int STAT_PROT_BIT = 5;
    // counter limits and fixed values
    localparam logic [15:0] CNT_START = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] PC_BLOCKED = 16'hFFFF;
    // revision, arbitrary value
    localparam logic [15:0] REVISION_DEFAULT = 16'h0100;
    // flash control register address and the mass-erase code, plain defaults
    localparam logic [11:0] FLASH_CTL_ADDR = 12'hFF8;
    localparam logic [11:0] FLASH_LAST_ADDR = 12'hFFF;
    localparam logic [7:0] FLASH_MASS_ERASE = 8'h63;
    // break length on error, in characters
    localparam logic [2:0] BREAK_CHARS = 3'h4;
    typedef enum logic [3:0] {
        ST_CMD, ST_ARG, ST_RDHI, ST_RDLO, ST_REG_AHI, ST_REG_ALO, ST_REG_SIZE, ST_REG_DATA, ST_BREAK
    } dbg_state_t;
endpackage

// File: cycle_counter.sv
// runtime counter: clears on leaving debug state, saturates, holds in debug state
module cycle_counter (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic debug_state_i,
    input wire logic clobber_i,
    input wire logic [15:0] clobber_val_i,
    output logic [15:0] count_o
);
    import dbg_cmd_pkg::*;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic debug_d_r;
    wire leaving = debug_d_r && !debug_state_i;
    wire at_max = (count_r == CNT_MAX);
    // restart on leaving debug, stick at the top, let commands overwrite it
    assign count_nxt = clobber_i ? clobber_val_i :
                       leaving ? CNT_START :
                       (!debug_state_i && !at_max) ? count_r + 16'h0001 : count_r;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            count_r <= CNT_START;
            debug_d_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            debug_d_r <= debug_state_i;
        end
    end
    assign count_o = count_r;
endmodule

// File: debug_command_interpreter.sv
//
// Behaviour
// RULE_01: outside debug state only revision, status, control write and read are accepted
// RULE_02: in debug state all commands work unless read protection restricts some; the code does nothing for 09H to 12H
// RULE_03: 00H returns major revision byte then minor revision byte
// RULE_04: 02H returns the status register byte
// RULE_05: 16-bit cycle counter from 0000H saturating at FFFFH; 03H returns high then low
// RULE_06: memory, register, step, stuff and execute commands may overwrite the counter
// RULE_07: 04H takes one following byte into the control register
// RULE_08: with protection, control writes may set bit 7 but never clear it
// RULE_09: 05H returns the control register byte
// RULE_10: 06H takes two bytes, high first, into the program counter
// RULE_11: program counter write is dropped outside debug state or with protection
// RULE_12: 07H returns the program counter high byte then low byte
// RULE_13: program counter read gives FFFFH outside debug state or with protection; the code drops 07H outside debug state with no reply
// RULE_14: register write moves 1 to 256 bytes; size 0 means 256
// RULE_15: register write outside debug state consumes bytes but writes nothing
// RULE_16: with protection, register writes reach only flash control registers
// RULE_17: with protection, only mass erase may enter the flash control register
// RULE_18: with protection, protected commands are disabled
// RULE_19: host sends address high nibble, address low, size, then data
// RULE_20: each byte is framed start, eight data bits lsb first, stop
// RULE_21: break, framing error or collision aborts command and sends four-character break
// RULE_22: reserved command bytes are ignored without reply
// RULE_23: first byte is a command; exactly its argument bytes follow
module debug_command_interpreter (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // receiver side: bytes already deframed
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_error_i,
    // transmitter side
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    output logic tx_break_o,
    output logic [2:0] tx_break_chars_o,
    input wire logic tx_break_done_i,
    // device state
    input wire logic read_protect_option_i,
    input wire logic halt_i,
    input wire logic brk_set_i,
    input wire logic [15:0] pc_i,
    output logic pc_wr_o,
    output logic [15:0] pc_o,
    output logic reg_wr_o,
    output logic [11:0] reg_addr_o,
    output logic [7:0] reg_data_o,
    output logic [7:0] debugger_control_register_o,
    output logic debug_state_bit_o,
    output logic busy_o
);
    import dbg_cmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // synchronise the option pin, which comes from outside the clock domain
    logic prot_s1_r;
    logic prot_r;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prot_s1_r <= 1'b0;
            prot_r <= 1'b0;
        end else begin
            prot_s1_r <= read_protect_option_i;
            prot_r <= prot_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer state and the bytes that a command carries
    dbg_state_t state_r;
    dbg_state_t state_nxt;
    logic [7:0] cmd_r;
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;
    logic [7:0] arg_r;
    logic [15:0] rd_word_r;
    logic [11:0] addr_r;
    logic [8:0] left_r;  // bytes still to come; nine bits hold 256
    logic [7:0] tx_data_r;
    logic [15:0] count;

    wire in_debug = ctl_r[CTL_DEBUG_STATE_BIT];
    // status: debug, halt, and a 1 while protection is off
    wire [7:0] status = {in_debug, halt_i, ~prot_r, 5'h00};

    // the receiver reports framing faults on rx_error_i, so only clean bytes count
    wire rx_take = rx_valid_i && !rx_error_i;  // RULE_20
    // a ready that comes before the byte is offered must not skip it
    wire tx_take = tx_ready_i && tx_valid_o;

    ////////////////////////////////////////////////////////////////////////
    // one named decode per command byte except 0DH and 0EH; one range decode covers 10H to 12H
    wire is_rev = (rx_data_i == CMD_REV_RD);
    wire is_stat = (rx_data_i == CMD_STAT_RD);
    wire is_cnt = (rx_data_i == CMD_CNT_RD);
    wire is_ctl_wr = (rx_data_i == CMD_CTL_WR);
    wire is_ctl_rd = (rx_data_i == CMD_CTL_RD);
    wire is_pc_wr = (rx_data_i == CMD_PC_WR);
    wire is_pc_rd = (rx_data_i == CMD_PC_RD);
    wire is_reg_wr = (rx_data_i == CMD_REG_WR);
    wire is_reg_rd = (rx_data_i == CMD_REG_RD);
    wire is_pmem_wr = (rx_data_i == CMD_PMEM_WR);
    wire is_pmem_rd = (rx_data_i == CMD_PMEM_RD);
    wire is_dmem_wr = (rx_data_i == CMD_DMEM_WR);
    wire is_instr = (rx_data_i >= CMD_STEP) && (rx_data_i <= CMD_EXEC);

    ////////////////////////////////////////////////////////////////////////
    // command gating by debug state and protection
    wire normal_cmd = is_rev || is_stat || is_ctl_wr || is_ctl_rd;  // RULE_01
    // a protected pc read is not dropped: it answers all ones instead
    wire prot_cmd = is_pc_wr || is_reg_rd || is_pmem_wr || is_pmem_rd ||
                    is_dmem_wr || is_instr;  // RULE_18
    wire cmd_ok = normal_cmd || (in_debug && !(prot_r && prot_cmd));  // RULE_02
    // pc and register writes still consume their bytes when blocked,
    // otherwise their argument bytes would be decoded as fresh commands
    wire consumes = is_ctl_wr || is_pc_wr || is_reg_wr;  // RULE_15
    wire pc_block = !in_debug || prot_r;  // RULE_11 RULE_13
    wire [15:0] pc_val = pc_block ? PC_BLOCKED : pc_i;

    ////////////////////////////////////////////////////////////////////////
    // word latched for the reply; single-byte replies sit in the top half
    wire [15:0] rd_word = is_rev ? REVISION_DEFAULT :  // RULE_03
                          is_cnt ? count :  // RULE_05
                          is_pc_rd ? pc_val :  // RULE_12
                          is_stat ? {status, 8'h00} :  // RULE_04
                          {ctl_r, 8'h00};  // RULE_09
    wire two_byte = is_rev || is_cnt || is_pc_rd;
    wire one_byte = is_stat || is_ctl_rd;

    // protected control write may only set the debug state bit
    wire [7:0] ctl_wr = prot_r ? {ctl_r[CTL_DEBUG_STATE_BIT] | rx_data_i[CTL_DEBUG_STATE_BIT],
                                  rx_data_i[6:0]} : rx_data_i;  // RULE_08

    // register write filters
    // under protection only the flash window takes data, and its control register only mass erase
    wire flash_addr = (addr_r >= FLASH_CTL_ADDR) && (addr_r <= FLASH_LAST_ADDR);
    wire reg_allow = in_debug && (!prot_r || (flash_addr &&
                     (addr_r != FLASH_CTL_ADDR || rx_data_i == FLASH_MASS_ERASE)));  // RULE_16 RULE_17
    wire reg_do = (state_r == ST_REG_DATA) && rx_take && reg_allow;

    ////////////////////////////////////////////////////////////////////////
    // command sequencer: command byte, argument bytes, then reply bytes
    always_comb begin
        state_nxt = state_r;
        ctl_nxt = ctl_r;
        case (state_r)
            ST_CMD: begin
                if (rx_take && cmd_ok) begin  // RULE_23
                    if (two_byte) state_nxt = ST_RDHI;
                    else if (one_byte) state_nxt = ST_RDLO;
                    else if (rx_data_i == CMD_REG_WR) state_nxt = ST_REG_AHI;
                    else if (rx_data_i == CMD_CTL_WR || rx_data_i == CMD_PC_WR) state_nxt = ST_ARG;
                end else if (rx_take && consumes) begin
                    state_nxt = (rx_data_i == CMD_REG_WR) ? ST_REG_AHI : ST_ARG;  // RULE_15
                end
                // anything else, reserved codes included, is dropped  RULE_22
            end
            ST_ARG: begin
                if (rx_take) begin
                    if (cmd_r == CMD_CTL_WR) begin
                        ctl_nxt = ctl_wr;  // RULE_07
                        state_nxt = ST_CMD;
                    end else if (left_r[0]) begin
                        state_nxt = ST_CMD;  // RULE_10
                    end
                end
            end
            // reply bytes leave one at a time as the transmitter takes them
            ST_RDHI: begin
                if (tx_take) state_nxt = ST_RDLO;
            end
            ST_RDLO: begin
                if (tx_take) state_nxt = ST_CMD;
            end
            // register write header: address nibble, address low, size
            ST_REG_AHI: begin
                if (rx_take) state_nxt = ST_REG_ALO;  // RULE_19
            end
            ST_REG_ALO: begin
                if (rx_take) state_nxt = ST_REG_SIZE;
            end
            ST_REG_SIZE: begin
                if (rx_take) state_nxt = ST_REG_DATA;
            end
            // the last data byte returns to command decode
            ST_REG_DATA: begin
                if (rx_take && left_r == 9'h001) state_nxt = ST_CMD;
            end
            // hold the break until the transmitter reports all four characters sent
            ST_BREAK: begin
                if (tx_break_done_i) state_nxt = ST_CMD;
            end
            default: state_nxt = ST_CMD;
        endcase
        // errors on the line abort whatever is running
        if (rx_error_i) state_nxt = ST_BREAK;  // RULE_21
        // a breakpoint in the same cycle as a control write still wins the debug bit
        if (brk_set_i) ctl_nxt[CTL_DEBUG_STATE_BIT] = 1'b1;
    end

    // the control register resets to normal operation
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= ST_CMD;
            ctl_r <= CTL_RESET;
        end else begin
            state_r <= state_nxt;
            ctl_r <= ctl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // argument and reply holding registers
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cmd_r <= 8'h00;
            arg_r <= 8'h00;
            rd_word_r <= 16'h0000;
            addr_r <= 12'h000;
            left_r <= 9'h000;
        end else if (state_r == ST_CMD && rx_take) begin
            // a fresh command clears the byte count left by the last one
            cmd_r <= rx_data_i;
            rd_word_r <= rd_word;
            left_r <= 9'h000;
        end else if (rx_take) begin
            case (state_r)
                ST_ARG: begin
                    arg_r <= rx_data_i;
                    left_r <= 9'h001;
                end
                // the upper address nibble arrives first; the rest of that byte is ignored
                ST_REG_AHI: addr_r <= {rx_data_i[3:0], 8'h00};
                ST_REG_ALO: addr_r <= {addr_r[11:8], rx_data_i};
                ST_REG_SIZE: left_r <= (rx_data_i == 8'h00) ? 9'h100 : {1'b0, rx_data_i};  // RULE_14
                // each data byte goes to the next register address
                ST_REG_DATA: begin
                    left_r <= left_r - 9'h001;
                    addr_r <= addr_r + 12'h001;
                end
                default: left_r <= left_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write strobes to the processor and register file; data from flops
    wire pc_do = (state_r == ST_ARG) && rx_take && left_r[0] && cmd_r == CMD_PC_WR && !pc_block;
    // strobes last one cycle; the value outputs hold until the next write
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pc_wr_o <= 1'b0;
            pc_o <= 16'h0000;
            reg_wr_o <= 1'b0;
            reg_addr_o <= 12'h000;
            reg_data_o <= 8'h00;
        end else begin
            pc_wr_o <= pc_do;  // RULE_11
            if (pc_do) pc_o <= {arg_r, rx_data_i};  // RULE_10
            reg_wr_o <= reg_do;  // RULE_15 RULE_16
            if (reg_do) begin
                reg_addr_o <= addr_r;
                reg_data_o <= rx_data_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reply byte, high byte first; single-byte replies keep it in the top half
    assign tx_data_r = (state_r == ST_RDHI) ? rd_word_r[15:8] :
                       (cmd_r == CMD_STAT_RD || cmd_r == CMD_CTL_RD) ? rd_word_r[15:8] : rd_word_r[7:0];
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) tx_data_o <= 8'h00;
        else tx_data_o <= tx_data_r;
    end
    // valid waits one cycle so the flopped data has settled
    logic tx_arm_r;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) tx_arm_r <= 1'b0;
        else tx_arm_r <= (state_nxt == ST_RDHI || state_nxt == ST_RDLO) && state_nxt == state_r;
    end
    assign tx_valid_o = tx_arm_r && (state_r == ST_RDHI || state_r == ST_RDLO);

    // break request holds until the transmitter reports it done
    assign tx_break_o = (state_r == ST_BREAK);  // RULE_21
    assign tx_break_chars_o = BREAK_CHARS;

    // state that the rest of the device watches
    assign debugger_control_register_o = ctl_r;
    assign debug_state_bit_o = in_debug;
    assign busy_o = (state_r != ST_CMD);

    ////////////////////////////////////////////////////////////////////////
    // register writes and program counter writes restart the counter from zero
    wire clobber = reg_do || pc_do;  // RULE_06
    cycle_counter u_cycle_counter (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .debug_state_i(in_debug),
        .clobber_i(clobber),
        .clobber_val_i(CNT_START),
        .count_o(count)  // RULE_05
    );
endmodule

// File: debug_command_interpreter_chk.sv
module debug_command_interpreter_chk
    import dbg_cmd_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_error_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic tx_break_o,
    input wire logic [2:0] tx_break_chars_o,
    input wire logic tx_break_done_i,
    input wire logic read_protect_option_i,
    input wire logic pc_wr_o,
    input wire logic [7:0] debugger_control_register_o,
    input wire logic debug_state_bit_o,
    input wire logic busy_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////
    // a command byte taken while idle; protection past its two-flop synchroniser
    sequence s_cmd(logic [7:0] c);
        !busy_o && rx_valid_i && !rx_error_i && rx_data_i == c;
    endsequence
    sequence s_prot;
        read_protect_option_i [*4];
    endsequence
    property p_rev;
        s_cmd(CMD_REV_RD) |-> ##2 tx_valid_o && tx_data_o == REVISION_DEFAULT[15:8];
    endproperty
    property p_ctl_rd;
        s_cmd(CMD_CTL_RD) |-> ##2 tx_valid_o && tx_data_o == debugger_control_register_o;
    endproperty
    property p_gate;
        s_cmd(CMD_PC_RD) ##0 !debug_state_bit_o |=> !busy_o [*3];
    endproperty
    property p_pc_blk;
        s_prot ##0 debug_state_bit_o ##0 s_cmd(CMD_PC_RD) |-> ##2 tx_data_o == PC_BLOCKED[15:8];
    endproperty
    property p_ctl_keep;
        s_prot ##0 debug_state_bit_o |=> debug_state_bit_o;
    endproperty
    property p_pc_nowr;
        s_prot |-> !pc_wr_o;
    endproperty
    property p_tx_hold;
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
    endproperty
    property p_err;
        rx_error_i |-> ##[0:3] tx_break_o;
    endproperty
    property p_brk_hold;
        tx_break_o && !tx_break_done_i |=> tx_break_o && tx_break_chars_o == BREAK_CHARS;
    endproperty
    property p_dbg_bit;
        debug_state_bit_o == debugger_control_register_o[CTL_DEBUG_STATE_BIT];
    endproperty
    a_rev: assert property (p_rev) else $error("revision reply late or wrong");
    a_ctl_rd: assert property (p_ctl_rd) else $error("control read reply wrong");
    a_gate: assert property (p_gate) else $error("gated command was accepted");
    a_pc_blk: assert property (p_pc_blk) else $error("blocked pc read not all ones");
    a_ctl_keep: assert property (p_ctl_keep) else $error("debug bit cleared under protection");
    a_pc_nowr: assert property (p_pc_nowr) else $error("pc written under protection");
    a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped before ready");
    a_err: assert property (p_err) else $error("no break after line error");
    a_brk_hold: assert property (p_brk_hold) else $error("break ended early or wrong length");
    a_dbg_bit: assert property (p_dbg_bit) else $error("debug bit differs from control bit 7");
endmodule

bind debug_command_interpreter debug_command_interpreter_chk debug_command_interpreter_chk_inst (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_error_i(rx_error_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
    .tx_break_o(tx_break_o), .tx_break_chars_o(tx_break_chars_o), .tx_break_done_i(tx_break_done_i),
    .read_protect_option_i(read_protect_option_i), .pc_wr_o(pc_wr_o),
    .debugger_control_register_o(debugger_control_register_o),
    .debug_state_bit_o(debug_state_bit_o), .busy_o(busy_o)
);

// File: debug_host_model.sv
module debug_host_model (
    input wire logic clk_sys_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_break_i,
    output logic rx_valid_o = 1'b0,
    output logic [7:0] rx_data_o = 8'h00,
    output logic rx_error_o = 1'b0,
    output logic tx_ready_o = 1'b0,
    output logic tx_break_done_o = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    int stall = 0;
    int brk_cnt = 0;
    // a four-character break is long on the wire, so done comes after a fixed wait
    always @(posedge clk_sys_i) begin
        brk_cnt <= tx_break_i ? brk_cnt + 1 : 0;
        tx_break_done_o <= tx_break_i && brk_cnt == 12;
    end
    // one whole character per call; the released data bus never shows the old byte
    task automatic send_byte(input logic [7:0] b, input logic err);
        @(posedge clk_sys_i);
        rx_valid_o <= !err;
        rx_error_o <= err;
        rx_data_o <= b;
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b0;
        rx_error_o <= 1'b0;
        rx_data_o <= ~b;
        repeat (3) @(posedge clk_sys_i);
    endtask
    // a reply that never comes returns unknown so the caller's compare fails
    task automatic recv_byte(output logic [7:0] b);
        b = 8'hXX;
        @(negedge clk_sys_i);
        for (int n = 0; n < 60 && tx_valid_i !== 1'b1; n++) @(negedge clk_sys_i);
        if (tx_valid_i !== 1'b1) return;
        repeat (stall) @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        tx_ready_o <= 1'b1;
        @(negedge clk_sys_i);
        b = tx_data_i;
        @(posedge clk_sys_i);
        tx_ready_o <= 1'b0;
    endtask
endmodule

// File: test_debug_command_interpreter.sv
module test_debug_command_interpreter;
    timeunit 1ns;
    timeprecision 1ns;
    import dbg_cmd_pkg::*;
    logic clk_sys_i = 1'b0, nrst_i = 1'b0, read_protect_option_i = 1'b0, halt_i = 1'b1, brk_set_i = 1'b0;
    logic [15:0] pc_i = 16'h0000;
    logic [15:0] pc_seen;
    logic tx_seen = 1'b0;
    logic [19:0] reg_q[$];
    wire rx_valid_i, rx_error_i, tx_ready_i, tx_break_done_i, tx_valid_o, tx_break_o;
    wire pc_wr_o, reg_wr_o, debug_state_bit_o, busy_o;
    wire [7:0] rx_data_i, tx_data_o, reg_data_o, debugger_control_register_o;
    wire [2:0] tx_break_chars_o;
    wire [15:0] pc_o;
    wire [11:0] reg_addr_o;
    int n_mismatch = 0, check_count = 0, cycles = 0, pc_wr_count = 0;
    debug_command_interpreter debug_command_interpreter_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_error_i(rx_error_i), .tx_valid_o(tx_valid_o),
        .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .tx_break_o(tx_break_o),
        .tx_break_chars_o(tx_break_chars_o), .tx_break_done_i(tx_break_done_i),
        .read_protect_option_i(read_protect_option_i), .halt_i(halt_i), .brk_set_i(brk_set_i), .pc_i(pc_i),
        .pc_wr_o(pc_wr_o), .pc_o(pc_o), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_data_o(reg_data_o),
        .debugger_control_register_o(debugger_control_register_o), .debug_state_bit_o(debug_state_bit_o),
        .busy_o(busy_o));
    debug_host_model debug_host_model_inst (.clk_sys_i(clk_sys_i), .tx_valid_i(tx_valid_o),
        .tx_data_i(tx_data_o), .tx_break_i(tx_break_o), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
        .rx_error_o(rx_error_i), .tx_ready_o(tx_ready_i), .tx_break_done_o(tx_break_done_i));
    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    ////////////////////////////////////////////////////////////
    // strobes last one cycle, so they are logged at the settled falling edge
    always @(negedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (tx_valid_o !== 1'b0) tx_seen <= 1'b1;
        if (reg_wr_o === 1'b1) reg_q.push_back({reg_addr_o, reg_data_o});
        if (pc_wr_o === 1'b1) pc_wr_count <= pc_wr_count + 1;
        if (pc_wr_o === 1'b1) pc_seen <= pc_o;
        if (cycles == 90000) n_mismatch++;
        if (cycles == 90000) close_out();
    end
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) n_mismatch++;
        if (got !== exp) $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    endtask
    task automatic put(input logic [7:0] b[$]);
        foreach (b[i]) debug_host_model_inst.send_byte(b[i], 1'b0);
    endtask
    // replies arrive high byte first
    task automatic get(output logic [15:0] v, input int nb);
        logic [7:0] b;
        v = 16'h0000;
        repeat (nb) begin
            debug_host_model_inst.recv_byte(b);
            v = {v[7:0], b};
        end
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_normal();
        logic [15:0] v;
        put({CMD_REV_RD});
        get(v, 2);
        check(v, REVISION_DEFAULT);
        put({CMD_STAT_RD});
        get(v, 1);
        check(v, 16'h0060);
        tx_seen = 1'b0;
        put({CMD_CNT_RD, CMD_PC_RD, 8'h01, 8'h0F, CMD_STEP, 8'h13, 8'hFF, CMD_PC_WR, 8'h12, 8'h34});
        put({CMD_REG_WR, 8'h00, 8'h10, 8'h01, 8'h55});
        check({tx_seen, pc_wr_count[3:0]}, 5'h00);
        check(20'(reg_q.size()), 20'h0);
        put({CMD_REV_RD});
        get(v, 2);
        check(v, REVISION_DEFAULT);
    endtask
    task automatic t_debug();
        logic [15:0] v;
        put({CMD_CTL_WR, 8'h80, CMD_CTL_RD});
        get(v, 1);
        check({debug_state_bit_o, v}, {1'b1, 16'h0080});
        put({CMD_STAT_RD});
        get(v, 1);
        check(v, 16'h00E0);
        put({CMD_PC_WR, 8'h12, 8'h34, CMD_CNT_RD});
        check({pc_wr_count[3:0], pc_seen}, 20'h11234);
        get(v, 2);
        check(v, CNT_START);
        pc_i <= 16'hABCD;
        put({CMD_PC_RD});
        get(v, 2);
        check(v, 16'hABCD);
        put({CMD_REG_WR, 8'h01, 8'h23, 8'h02, 8'hAA, 8'hBB});
        check(reg_q[0], 20'h123AA);
        check(reg_q[1], 20'h124BB);
        reg_q.delete();
        put({CMD_REG_WR, 8'h00, 8'h00, 8'h00});
        repeat (256) put({8'h5A});
        check(20'(reg_q.size()), 20'd256);
    endtask
    // leave debug long enough to saturate, then come back through a breakpoint
    task automatic t_count();
        logic [15:0] v;
        put({CMD_CTL_WR, 8'h00});
        repeat (66000) @(posedge clk_sys_i);
        brk_set_i <= 1'b1;
        @(posedge clk_sys_i);
        brk_set_i <= 1'b0;
        put({CMD_CNT_RD});
        get(v, 2);
        check(v, CNT_MAX);
    endtask
    task automatic t_protect();
        logic [15:0] v;
        read_protect_option_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        put({CMD_CTL_WR, 8'h00, CMD_CTL_RD});
        get(v, 1);
        check(v[7], 1'b1);
        put({CMD_PC_RD});
        get(v, 2);
        check(v, PC_BLOCKED);
        reg_q.delete();
        put({CMD_PC_WR, 8'h55, 8'h66, CMD_REG_WR, 8'h00, 8'h10, 8'h01, 8'h77});
        put({CMD_REG_WR, 8'h0F, 8'hF8, 8'h01, 8'h12, CMD_REG_WR, 8'h0F, 8'hF8, 8'h01, FLASH_MASS_ERASE});
        check({pc_wr_count[3:0], 16'(reg_q.size())}, 20'h10001);
        check(reg_q[0], {FLASH_CTL_ADDR, FLASH_MASS_ERASE});
    endtask
    // a line error in mid-command, then a slow host on the next reply
    task automatic t_error();
        logic [15:0] v;
        read_protect_option_i <= 1'b0;
        put({CMD_PC_WR, 8'h12});
        debug_host_model_inst.send_byte(8'h00, 1'b1);
        for (int n = 0; n < 20 && tx_break_o !== 1'b1; n++) @(negedge clk_sys_i);
        check({tx_break_o, tx_break_chars_o}, {1'b1, BREAK_CHARS});
        for (int n = 0; n < 60 && busy_o !== 1'b0; n++) @(negedge clk_sys_i);
        debug_host_model_inst.stall = 3;
        put({CMD_REV_RD});
        get(v, 2);
        check({pc_wr_count[3:0], v}, {4'h1, REVISION_DEFAULT});
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        t_normal();
        $display("normal mode test done");
        t_debug();
        $display("debug mode test done");
        t_count();
        $display("counter test done");
        t_protect();
        $display("protection test done");
        t_error();
        $display("line error test done");
        close_out();
    end
endmodule
